//--- hdl/isfl_pkg.sv
// Constants and state types for the serial bus status flag block.
// Assumes a 32-bit APB register port and byte-wide bus traffic.
package isfl_pkg;

    // Register byte addresses.
    localparam int                 ISFL_AW          = 12;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_STATUS  = 12'h000;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_TXBUF   = 12'h004;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_RXBUF   = 12'h008;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_OWNADR  = 12'h00C;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_INTSTAT = 12'h010;
    localparam logic [ISFL_AW-1:0] ISFL_OFF_INTMASK = 12'h014;

    // Bit positions in serial_bus_status.
    localparam int ISFL_ST_TEN_BIT_ADDR_MATCHED = 8;
    localparam int ISFL_ST_WCOL  = 7;
    localparam int ISFL_ST_OV    = 6;
    localparam int ISFL_ST_DA    = 5;
    localparam int ISFL_ST_BUSY  = 2;
    localparam int ISFL_ST_RBF   = 1;

    // Bit positions in the interrupt status and mask registers.
    localparam int ISFL_IRQ_N    = 4;
    localparam int ISFL_IRQ_WCOL = 0;
    localparam int ISFL_IRQ_OV   = 1;
    localparam int ISFL_IRQ_RX   = 2;
    localparam int ISFL_IRQ_STOP = 3;

    // Ten-bit address header is 11110 followed by two high address bits.
    localparam logic [4:0] ISFL_HDR_PATTERN = 5'h1E;

    // Level of a released bus line, held up by the pull-ups; the pin stages reset to it.
    localparam logic ISFL_LINE_IDLE = 1'b1;

    // Byte position after a Start condition.
    localparam logic [1:0] ISFL_IDX_FIRST  = 2'h0;
    localparam logic [1:0] ISFL_IDX_SECOND = 2'h1;
    localparam logic [1:0] ISFL_IDX_DATA   = 2'h2;

    // Eight data clocks, then one acknowledge clock per byte.
    localparam logic [3:0] ISFL_LAST_BIT = 4'h7;
    localparam logic [3:0] ISFL_ACK_BIT  = 4'h8;

    // Byte receiver state.
    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] data;
        logic       done;
    } isfl_rx_state_t;

    // Main block state.
    typedef struct packed {
        logic                  scl_meta;
        logic                  scl_sync;
        logic                  scl_prev;
        logic                  sda_meta;
        logic                  sda_sync;
        logic                  sda_prev;
        logic                  busy;
        logic                  hdr_match;
        logic [1:0]            byte_idx;
        logic                  ten_bit_addr_matched;
        logic                  wcol;
        logic                  ov;
        logic                  d_a;
        logic                  rbf;
        logic [7:0]            rx_data;
        logic [7:0]            tx_data;
        logic [9:0]            own_addr;
        logic [ISFL_IRQ_N-1:0] int_stat;
        logic [ISFL_IRQ_N-1:0] int_mask;
        logic [31:0]           prdata;
    } isfl_state_t;

endpackage

//--- hdl/isfl_byte_rx.sv
// Byte receiver that shifts serial data on clock rising edges.
// Assumes synchronised, edge-detected bus inputs from the same clock domain.
`timescale 1ns/100ps
module isfl_byte_rx (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Bus events, already synchronised.
    input  wire logic       frame_restart,
    input  wire logic       scl_rise,
    input  wire logic       sda_bit,
    // Received byte.
    output logic            byte_done,
    output logic [7:0]      byte_data
);

    isfl_pkg::isfl_rx_state_t st_reg;
    isfl_pkg::isfl_rx_state_t st_next;

    // Count eight data clocks, skip the acknowledge clock, restart on Start or Stop.
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (frame_restart) begin
            st_next.bit_cnt = '0;
        end else if (scl_rise) begin
            if (st_reg.bit_cnt == isfl_pkg::ISFL_ACK_BIT) begin
                st_next.bit_cnt = '0;
            end else begin
                st_next.shift   = {st_reg.shift[6:0], sda_bit};
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                if (st_reg.bit_cnt == isfl_pkg::ISFL_LAST_BIT) begin
                    st_next.data = {st_reg.shift[6:0], sda_bit};
                    st_next.done = 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign byte_done = st_reg.done;
    assign byte_data = st_reg.data;

endmodule

//--- hdl/isfl_status_flags.sv
// Status flag logic of a two-wire serial bus controller with an APB register port.
// Assumes SCL and SDA arrive asynchronously; APB runs on CLK_SYS at 100 MHz.
`timescale 1ns/100ps

// Behaviour
// RL1: Ten-bit match sets flag; Stop clears it.
// RL2: Transmit write while busy sets collision flag.
// RL3: Collision flag stays until software clears.
// RL4: Byte arriving with full buffer flags overflow.
// RL5: Overflow set on transfer attempt, software clears.
// RL6: Slave data/address indicator tracks last byte.
// RL7: Reset clears every status flag.
module isfl_status_flags (
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Serial bus pins, observed only.
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    // Interrupt.
    output logic             IRQ
);

    isfl_pkg::isfl_state_t st_reg;
    isfl_pkg::isfl_state_t st_next;

    logic       scl_rise;
    logic       start_det;
    logic       stop_det;
    logic       rx_done;
    logic [7:0] rx_byte;
    logic       setup_ph;
    logic       wr_acc;
    logic       rd_acc;
    logic       mapped;
    logic       wr_status;
    logic       wr_txbuf;
    logic       rd_rxbuf;
    logic       wcol_clr;
    logic       ov_clr;
    logic       wcol_set;
    logic       ov_set;
    logic       ten_bit_addr_matched_set;
    logic       hdr_now;
    logic [15:0] status_word;
    logic [isfl_pkg::ISFL_IRQ_N-1:0] events;

    // Bus conditions seen on the synchronised pins.
    assign scl_rise  = st_reg.scl_sync & ~st_reg.scl_prev;
    assign start_det = st_reg.scl_sync & st_reg.scl_prev & st_reg.sda_prev & ~st_reg.sda_sync;
    assign stop_det  = st_reg.scl_sync & st_reg.scl_prev & ~st_reg.sda_prev & st_reg.sda_sync;

    // Byte assembly lives in its own module.
    isfl_byte_rx u_rx (
        .clk           (CLK_SYS),
        .rst           (RST),
        .frame_restart (start_det | stop_det),
        .scl_rise      (scl_rise),
        .sda_bit       (st_reg.sda_sync),
        .byte_done     (rx_done),
        .byte_data     (rx_byte)
    );

    // APB decode; the slave never inserts wait states.
    assign setup_ph  = PSEL & ~PENABLE;
    assign wr_acc    = PSEL & PENABLE & PWRITE;
    assign rd_acc    = PSEL & PENABLE & ~PWRITE;
    assign wr_status = wr_acc & (PADDR == isfl_pkg::ISFL_OFF_STATUS);
    assign wr_txbuf  = wr_acc & (PADDR == isfl_pkg::ISFL_OFF_TXBUF);
    assign rd_rxbuf  = rd_acc & (PADDR == isfl_pkg::ISFL_OFF_RXBUF);
    assign wcol_clr  = wr_status & PWDATA[isfl_pkg::ISFL_ST_WCOL];
    assign ov_clr    = wr_status & PWDATA[isfl_pkg::ISFL_ST_OV];

    always_comb begin
        case (PADDR)
            isfl_pkg::ISFL_OFF_STATUS,
            isfl_pkg::ISFL_OFF_TXBUF,
            isfl_pkg::ISFL_OFF_RXBUF,
            isfl_pkg::ISFL_OFF_OWNADR,
            isfl_pkg::ISFL_OFF_INTSTAT,
            isfl_pkg::ISFL_OFF_INTMASK: mapped = 1'b1;
            default:                    mapped = 1'b0;
        endcase
    end

    // Zero wait states: every access takes two cycles, which a slave this small can afford.
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign PRDATA  = st_reg.prdata;

    // The direction bit of the header byte takes no part in the match.
    // RL1: header match test
    assign hdr_now = (rx_byte[7:3] == isfl_pkg::ISFL_HDR_PATTERN) && (rx_byte[2:1] == st_reg.own_addr[9:8]);
    // RL1: second byte match
    assign ten_bit_addr_matched_set = rx_done && (st_reg.byte_idx == isfl_pkg::ISFL_IDX_SECOND) && st_reg.hdr_match
                       && (rx_byte == st_reg.own_addr[7:0]);
    // RL2: busy write detect
    assign wcol_set = wr_txbuf & st_reg.busy;
    // RL4: full buffer detect
    assign ov_set = rx_done & st_reg.rbf;

    // Status word as software sees it.
    always_comb begin
        status_word                          = '0;
        status_word[isfl_pkg::ISFL_ST_TEN_BIT_ADDR_MATCHED] = st_reg.ten_bit_addr_matched;
        status_word[isfl_pkg::ISFL_ST_WCOL]  = st_reg.wcol;
        status_word[isfl_pkg::ISFL_ST_OV]    = st_reg.ov;
        status_word[isfl_pkg::ISFL_ST_DA]    = st_reg.d_a;
        status_word[isfl_pkg::ISFL_ST_BUSY]  = st_reg.busy;
        status_word[isfl_pkg::ISFL_ST_RBF]   = st_reg.rbf;
    end

    // Interrupt sources, one pulse per event.
    always_comb begin
        events                          = '0;
        events[isfl_pkg::ISFL_IRQ_WCOL] = wcol_set;
        events[isfl_pkg::ISFL_IRQ_OV]   = ov_set;
        events[isfl_pkg::ISFL_IRQ_RX]   = rx_done;
        events[isfl_pkg::ISFL_IRQ_STOP] = stop_det;
    end

    // Next state; every flag lets a set in the same cycle win over a software clear.
    always_comb begin
        st_next          = st_reg;
        // Two flip-flops before any logic looks at the pins, then one for edges.
        st_next.scl_meta = SCL_IN;
        st_next.scl_sync = st_reg.scl_meta;
        st_next.scl_prev = st_reg.scl_sync;
        st_next.sda_meta = SDA_IN;
        st_next.sda_sync = st_reg.sda_meta;
        st_next.sda_prev = st_reg.sda_sync;

        // Bus busy between Start and Stop.
        if (start_det) begin
            st_next.busy     = 1'b1;
            st_next.byte_idx = isfl_pkg::ISFL_IDX_FIRST;
        end else if (stop_det) begin
            st_next.busy = 1'b0;
        end

        // RL1: clear at Stop
        if (stop_det) begin
            st_next.ten_bit_addr_matched = 1'b0;
        end else if (ten_bit_addr_matched_set) begin
            st_next.ten_bit_addr_matched = 1'b1;
        end

        // A seven-bit address frame turns to data from its second byte on.
        // RL6: address or data byte
        if (rx_done) begin
            if (st_reg.byte_idx == isfl_pkg::ISFL_IDX_FIRST) begin
                st_next.d_a       = 1'b0;
                st_next.hdr_match = hdr_now;
                st_next.byte_idx  = isfl_pkg::ISFL_IDX_SECOND;
            end else if (st_reg.byte_idx == isfl_pkg::ISFL_IDX_SECOND && st_reg.hdr_match) begin
                st_next.d_a      = 1'b0;
                st_next.byte_idx = isfl_pkg::ISFL_IDX_DATA;
            end else begin
                st_next.d_a      = 1'b1;
                st_next.byte_idx = isfl_pkg::ISFL_IDX_DATA;
            end
        end

        // RL5: overflow on transfer attempt
        if (ov_set) begin
            st_next.ov = 1'b1;
        end else if (ov_clr) begin
            st_next.ov = 1'b0;
        end

        // The buffer keeps the unread byte when the new one overflows.
        // Software must read it before the next byte completes, or that byte is lost.
        if (rx_done && !st_reg.rbf) begin
            st_next.rx_data = rx_byte;
            st_next.rbf     = 1'b1;
        end else if (rd_rxbuf) begin
            st_next.rbf = 1'b0;
        end

        // RL3: only software clears
        if (wcol_set) begin
            st_next.wcol = 1'b1;
        end else if (wcol_clr) begin
            st_next.wcol = 1'b0;
        end

        // A colliding transmit write is dropped so the byte in flight stays intact.
        if (wr_txbuf && !st_reg.busy) begin
            st_next.tx_data = PWDATA[7:0];
        end
        if (wr_acc && PADDR == isfl_pkg::ISFL_OFF_OWNADR) begin
            st_next.own_addr = PWDATA[9:0];
        end
        if (wr_acc && PADDR == isfl_pkg::ISFL_OFF_INTMASK) begin
            st_next.int_mask = PWDATA[isfl_pkg::ISFL_IRQ_N-1:0];
        end
        // A new event beats a write-one-to-clear of the same bit.
        if (wr_acc && PADDR == isfl_pkg::ISFL_OFF_INTSTAT) begin
            st_next.int_stat = (st_reg.int_stat & ~PWDATA[isfl_pkg::ISFL_IRQ_N-1:0]) | events;
        end else begin
            st_next.int_stat = st_reg.int_stat | events;
        end

        // Read data is latched in the setup phase and held through the access phase.
        if (setup_ph && !PWRITE) begin
            case (PADDR)
                isfl_pkg::ISFL_OFF_STATUS:  st_next.prdata = {16'h0000, status_word};
                isfl_pkg::ISFL_OFF_TXBUF:   st_next.prdata = {24'h000000, st_reg.tx_data};
                isfl_pkg::ISFL_OFF_RXBUF:   st_next.prdata = {24'h000000, st_reg.rx_data};
                isfl_pkg::ISFL_OFF_OWNADR:  st_next.prdata = {22'h0, st_reg.own_addr};
                isfl_pkg::ISFL_OFF_INTSTAT: st_next.prdata = {28'h0000000, st_reg.int_stat};
                isfl_pkg::ISFL_OFF_INTMASK: st_next.prdata = {28'h0000000, st_reg.int_mask};
                default:                    st_next.prdata = '0;
            endcase
        end
    end

    // Pin stages reset to the idle line level; a low reset value would show a
    // false clock edge just after reset and count a bit outside any frame.
    // RL7: reset clears flags
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_reg          <= '0;
            st_reg.scl_meta <= isfl_pkg::ISFL_LINE_IDLE;
            st_reg.scl_sync <= isfl_pkg::ISFL_LINE_IDLE;
            st_reg.scl_prev <= isfl_pkg::ISFL_LINE_IDLE;
            st_reg.sda_meta <= isfl_pkg::ISFL_LINE_IDLE;
            st_reg.sda_sync <= isfl_pkg::ISFL_LINE_IDLE;
            st_reg.sda_prev <= isfl_pkg::ISFL_LINE_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Level interrupt while any unmasked event bit is set.
    assign IRQ = |(st_reg.int_stat & st_reg.int_mask);

    // Checks sample on the system clock and, except chk_reset_flags, rest while reset is high.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // Flag checks.
    chk_ten_bit_addr_matched_set: assert property (ten_bit_addr_matched_set && !stop_det |=> st_reg.ten_bit_addr_matched) // RL1
        else $error("Ten-bit match did not set the flag.");
    chk_ten_bit_addr_matched_stop: assert property (stop_det |=> !st_reg.ten_bit_addr_matched ##1 (st_reg.ten_bit_addr_matched == $past(ten_bit_addr_matched_set))) // RL1
        else $error("Stop did not clear the ten-bit flag.");
    chk_wcol_set: assert property (wr_txbuf && st_reg.busy |=> // RL2
        st_reg.wcol && st_reg.tx_data == $past(st_reg.tx_data))
        else $error("Busy transmit write not flagged or not dropped.");
    chk_wcol_hold: assert property (st_reg.wcol && !wcol_clr |=> st_reg.wcol) // RL3
        else $error("Collision flag cleared without software.");
    chk_ov_set: assert property (rx_done && st_reg.rbf |=> st_reg.ov && st_reg.rx_data == $past(st_reg.rx_data)) // RL4
        else $error("Overflow not flagged or buffer overwritten.");
    chk_ov_quiet: assert property (!st_reg.ov && !(rx_done && st_reg.rbf) |=> !st_reg.ov) // RL4
        else $error("Overflow flag rose without cause.");
    chk_ov_hold: assert property (st_reg.ov && !ov_clr |=> st_reg.ov) // RL5
        else $error("Overflow flag cleared without software.");
    chk_da_data: assert property (rx_done && st_reg.byte_idx == isfl_pkg::ISFL_IDX_DATA |=> st_reg.d_a) // RL6
        else $error("Data byte did not set the indicator.");
    chk_reset_flags: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        $past(RST) |-> !(st_reg.ten_bit_addr_matched || st_reg.wcol || st_reg.ov || st_reg.d_a || st_reg.rbf)) // RL7
        else $error("Flags not zero after reset.");

    // Hold and clear checks.
    chk_ten_bit_addr_matched_hold: assert property (st_reg.ten_bit_addr_matched && !stop_det |=> st_reg.ten_bit_addr_matched) // RL1
        else $error("Ten-bit flag dropped before Stop.");
    chk_ten_bit_addr_matched_quiet: assert property (!st_reg.ten_bit_addr_matched && !ten_bit_addr_matched_set |=> !st_reg.ten_bit_addr_matched) // RL1
        else $error("Ten-bit flag rose without a match.");
    chk_wcol_quiet: assert property (!st_reg.wcol && !wcol_set |=> !st_reg.wcol) // RL2
        else $error("Collision flag rose without a busy write.");
    chk_wcol_clear: assert property (wcol_clr && !wcol_set |=> !st_reg.wcol) // RL3
        else $error("Software clear of the collision flag ignored.");
    chk_ov_clear: assert property (ov_clr && !ov_set |=> !st_reg.ov) // RL5
        else $error("Software clear of the overflow flag ignored.");

    // Bus tracking and buffer checks.
    chk_da_addr: assert property (rx_done && st_reg.byte_idx == isfl_pkg::ISFL_IDX_FIRST |=> !st_reg.d_a) // RL6
        else $error("Address byte did not clear the indicator.");
    chk_da_hold: assert property (!rx_done |=> st_reg.d_a == $past(st_reg.d_a)) // RL6
        else $error("Indicator moved without a received byte.");
    chk_rbf_load: assert property (rx_done && !st_reg.rbf |=> st_reg.rbf && st_reg.rx_data == $past(rx_byte)) // RL4
        else $error("Received byte not loaded into an empty buffer.");
    chk_busy_start: assert property (start_det |=> st_reg.busy) // RL2
        else $error("Start did not mark the bus busy.");
    chk_busy_stop: assert property (stop_det |=> !st_reg.busy) // RL2
        else $error("Stop did not mark the bus free.");

    // Main scenarios.
    cov_ten_bit_addr_matched: cover property (ten_bit_addr_matched_set ##[1:1000] stop_det);
    cov_wcol: cover property (wcol_set ##1 wcol_clr);
    cov_overflow: cover property (ov_set);
    cov_irq: cover property ($rose(IRQ));
    cov_data_byte: cover property (rx_done && st_reg.byte_idx == isfl_pkg::ISFL_IDX_DATA);

endmodule

//--- test/isfl_bus_model.sv
// Behavioural bus master that drives the two-wire clock and data lines.
// Assumes pull-ups on both lines, so a released line reads high.
`timescale 1ns/100ps
module isfl_bus_model (
    // Bus lines.
    output logic scl,
    output logic sda
);
    // Both lines idle high; the clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Calls start on a system clock edge and every step is a multiple of the clock
    // period, so lines change by non-blocking assignment to avoid a race with sampling.
    // Start: data falls while the clock is high.
    task automatic start_cond();
        sda <= 1'b0;
        #40;
        scl <= 1'b0;
        #20;
    endtask

    // One 80 ns clock pulse; data only ever moves while the clock is low.
    task automatic pulse();
        #20 scl <= 1'b1;
        #40 scl <= 1'b0;
        #20;
    endtask

    // Eight bits, most significant first, then a released acknowledge slot.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda <= b[i];
            pulse();
        end
        sda <= 1'b1;
        pulse();
    endtask

    // Stop: data rises while the clock is high.
    task automatic stop_cond();
        sda <= 1'b0;
        #20 scl <= 1'b1;
        #20 sda <= 1'b1;
        #40;
    endtask
endmodule

//--- test/isfl_status_flags_test.sv
// Self-checking bench for the serial bus status flag block.
// Assumes the behavioural bus master model and zero-wait APB answers.
`timescale 1ns/100ps
module isfl_status_flags_test;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        scl;
    logic        sda;
    logic        last_err;
    logic [31:0] seed    = 32'h1BEAF887;
    logic [31:0] tmp;
    logic [9:0]  own;
    logic [7:0]  hdr;
    logic [7:0]  d1;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    isfl_status_flags i_isfl_status_flags (
        .CLK_SYS (clk_sys), .RST (rst), .PSEL (psel), .PENABLE (penable), .PWRITE (pwrite),
        .PADDR (paddr), .PWDATA (pwdata), .PRDATA (prdata), .PREADY (pready), .PSLVERR (pslverr),
        .SCL_IN (scl), .SDA_IN (sda), .IRQ (irq)
    );
    isfl_bus_model i_isfl_bus_model (.scl (scl), .sda (sda));

    // System clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;

    // Hang guard: the full run needs under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected status word, built from the package bit positions.
    function automatic logic [31:0] st(input int a10, wc, ov, da, bsy, rbf);
        logic [31:0] v;
        v = 32'h0;
        v[isfl_pkg::ISFL_ST_TEN_BIT_ADDR_MATCHED] = (a10 != 0);
        v[isfl_pkg::ISFL_ST_WCOL]  = (wc != 0);
        v[isfl_pkg::ISFL_ST_OV]    = (ov != 0);
        v[isfl_pkg::ISFL_ST_DA]    = (da != 0);
        v[isfl_pkg::ISFL_ST_BUSY]  = (bsy != 0);
        v[isfl_pkg::ISFL_ST_RBF]   = (rbf != 0);
        return v;
    endfunction

    // One APB transfer; request held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    // Main sequence: reset, then frames from the bus model mixed with register traffic.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(isfl_pkg::ISFL_OFF_STATUS, 32'h0);
        rd(isfl_pkg::ISFL_OFF_INTSTAT, 32'h0);
        check({31'h0, last_err}, 32'h0);
        rd(12'h018, 32'h0);
        check({31'h0, last_err}, 32'h1);
        tmp = rnd();
        own = tmp[9:0];
        hdr = {isfl_pkg::ISFL_HDR_PATTERN, own[9:8], 1'b0};
        wr(isfl_pkg::ISFL_OFF_OWNADR, {22'h0, own});
        // Frame with a wrong second byte leaves the match flag clear.
        i_isfl_bus_model.start_cond();
        i_isfl_bus_model.send_byte(hdr);
        rd(isfl_pkg::ISFL_OFF_RXBUF, {24'h0, hdr});
        i_isfl_bus_model.send_byte(own[7:0] ^ (tmp[17:10] | 8'h01));
        rd(isfl_pkg::ISFL_OFF_STATUS, st(0, 0, 0, 0, 1, 1));
        rd(isfl_pkg::ISFL_OFF_RXBUF, {24'h0, own[7:0] ^ (tmp[17:10] | 8'h01)});
        i_isfl_bus_model.stop_cond();
        // Matching frame with two data bytes and a transmit write while busy.
        tmp = rnd();
        d1  = tmp[7:0];
        i_isfl_bus_model.start_cond();
        i_isfl_bus_model.send_byte(hdr);
        rd(isfl_pkg::ISFL_OFF_RXBUF, {24'h0, hdr});
        i_isfl_bus_model.send_byte(own[7:0]);
        rd(isfl_pkg::ISFL_OFF_STATUS, st(1, 0, 0, 0, 1, 1));
        rd(isfl_pkg::ISFL_OFF_RXBUF, {24'h0, own[7:0]});
        i_isfl_bus_model.send_byte(d1);
        rd(isfl_pkg::ISFL_OFF_STATUS, st(1, 0, 0, 1, 1, 1));
        wr(isfl_pkg::ISFL_OFF_TXBUF, {24'h0, tmp[15:8]});
        i_isfl_bus_model.send_byte(tmp[23:16]);
        rd(isfl_pkg::ISFL_OFF_STATUS, st(1, 1, 1, 1, 1, 1));
        rd(isfl_pkg::ISFL_OFF_RXBUF, {24'h0, d1});
        i_isfl_bus_model.stop_cond();
        rd(isfl_pkg::ISFL_OFF_STATUS, st(0, 1, 1, 1, 0, 0));
        wr(isfl_pkg::ISFL_OFF_STATUS, 32'h0);
        rd(isfl_pkg::ISFL_OFF_STATUS, st(0, 1, 1, 1, 0, 0));
        wr(isfl_pkg::ISFL_OFF_STATUS, st(0, 0, 1, 0, 0, 0));
        rd(isfl_pkg::ISFL_OFF_STATUS, st(0, 1, 0, 1, 0, 0));
        wr(isfl_pkg::ISFL_OFF_STATUS, st(0, 1, 0, 0, 0, 0));
        wr(isfl_pkg::ISFL_OFF_TXBUF, {24'h0, d1});
        rd(isfl_pkg::ISFL_OFF_STATUS, st(0, 0, 0, 1, 0, 0));
        // Interrupt: all four events pending, then masked, the Stop event unmasked, and all four cleared.
        rd(isfl_pkg::ISFL_OFF_INTSTAT, 32'h0000000F);
        check({31'h0, irq}, 32'h0);
        wr(isfl_pkg::ISFL_OFF_INTMASK, 32'h1 << isfl_pkg::ISFL_IRQ_STOP);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        wr(isfl_pkg::ISFL_OFF_INTSTAT, 32'h0000000F);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        // Reset in mid-frame with flags raised clears them all.
        i_isfl_bus_model.start_cond();
        i_isfl_bus_model.send_byte(hdr);
        i_isfl_bus_model.send_byte(own[7:0]);
        wr(isfl_pkg::ISFL_OFF_TXBUF, 32'h0);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(isfl_pkg::ISFL_OFF_STATUS, 32'h0);
        rd(isfl_pkg::ISFL_OFF_INTSTAT, 32'h0);
        check({31'h0, irq}, 32'h0);
        i_isfl_bus_model.stop_cond();
        close_out();
    end
endmodule
